// *** logic/sea_defines.svh ***
// Purpose: constants of the serial eeprom access and guard block
// Assumes: included by its bare name
// Notes: opcodes, status bit positions, bus offsets, timing counts
`ifndef SEA_DEFINES_SVH
`define SEA_DEFINES_SVH
`define SEA_OP_LATCH_SET   8'h06
`define SEA_OP_LATCH_CLR   8'h04
`define SEA_OP_STAT_READ   8'h05
`define SEA_OP_STAT_WRITE  8'h01
`define SEA_OP_ARRAY_READ  8'h03
`define SEA_OP_ARRAY_WRITE 8'h02
`define SEA_SR_GUARD_EN    7
`define SEA_SR_BG_HI       3
`define SEA_SR_BG_LO       2
`define SEA_SR_LATCH       1
`define SEA_SR_BUSY        0
`define SEA_SR_BUSY_VIEW   8'hFF
`define SEA_ADDR_TOP       14'h3FFF
`define SEA_QUARTER_BASE   14'h3000
`define SEA_HALF_BASE      14'h2000
`define SEA_OPC_LAST       4'h7
`define SEA_ADDR_LAST      4'hF
`define SEA_PAGE_BYTES     16'h0020
`define SEA_REG_STATUS     4'h0
`define SEA_REG_WTIME      4'h4
`define SEA_WTIME_RESET    16'h0100
`define SEA_WTIME_MIN      16'h0040
`define SEA_SYNC_RESET     4'h9
`endif

// *** logic/sea_engine.sv ***
// Purpose: device-side serial eeprom command engine with write guarding
// Assumes: link pins oversampled by core_clk_in at 250 MHz; Avalon-MM registers
// Notes: link clock edges are found from the synchronised pin level
// Notes on behaviour
// R1: guard pin low with guard-enable set makes the device hardware protected.
// R2: guard pin high or guard-enable clear removes hardware protection.
// R3: hardware protection blocks status writes and guarded blocks, not free blocks.
// R4: host sets write latch first; latch clear protects everything.
// R5: input sampled on link clock rise, output changed on its fall.
// R6: read is opcode plus 16 address bits; low 14 bits used.
// R7: read address advances by one after each byte shifted out.
// R8: read address wraps from top location to zero.
// R9: select rising ends and abandons any read.
// R10: status read shifts status out, allowed during an internal write.
// R11: latch set counts only if select rises right after its eighth bit.
// R12: host holds select low over whole array write, at least 32 clocks.
// R13: one to 32 data bytes per write, all in one page.
// R14: write pointer wraps inside the page, overwriting earlier bytes.
// R15: write starts only if select rises right after a data byte's bit 0.
// R16: host sends status bits 0, 1, 4, 5, 6 as zero.
// R17: busy flag reads 1 through the whole internal write.
// R18: opcodes are eight bits, msb first, with fixed codes.
// R19: status holds guard-enable, block guards, latch and busy; last two read-only.
// R20: block guard field picks none, upper quarter, upper half or all.
// R21: latch cleared at reset and after each completed write cycle.
// R22: serial output floats when deselected; driven only while shifting out.
//
// The implementer's own choices: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`include "sea_defines.svh"
module sea_engine import sea_pkg::*; #(
   parameter logic [15:0] WRITE_CYCLES = `SEA_WTIME_RESET
) (
   // clock and reset
   input  wire logic        core_clk_in,
   input  wire logic        rst_b_in,
   // register bus
   input  wire logic [3:0]  avs_address_in,
   input  wire logic        avs_read_in,
   input  wire logic        avs_write_in,
   input  wire logic [31:0] avs_writedata_in,
   input  wire logic [3:0]  avs_byteenable_in,
   output logic      [31:0] avs_readdata_out,
   output logic             avs_waitrequest_out,
   // serial link
   input  wire logic        spi_sck_in,
   input  wire logic        spi_cs_b_in,
   input  wire logic        spi_si_in,
   input  wire logic        guard_pin_b_in,
   output logic             spi_so_out,
   output logic             spi_so_oe_b_out
);
   if (WRITE_CYCLES < `SEA_WTIME_MIN) begin : g_bad_wtime
      $error("write cycle count too short to program a page");
   end

   sea_state_t st_reg;
   sea_state_t st_next;
   logic [7:0] mem [0:16383];
   logic [3:0] pins_s;
   logic       cs_b_s, sck_s, si_s, wp_b_s;
   logic       sck_rise, sck_fall, cs_rise, hwp;
   logic       mem_we;
   logic [13:0] mem_wa;
   logic [7:0] mem_wd;

   sea_sync #(
      .W       (4),
      .RST_VAL (`SEA_SYNC_RESET)
   ) u_sync (
      .core_clk_in (core_clk_in),
      .rst_b_in    (rst_b_in),
      .d_in        ({spi_cs_b_in, spi_sck_in, spi_si_in, guard_pin_b_in}),
      .q_out       (pins_s)
   );

   assign {cs_b_s, sck_s, si_s, wp_b_s} = pins_s;
   assign sck_rise = sck_s & ~st_reg.sck_q;
   assign sck_fall = ~sck_s & st_reg.sck_q;
   assign cs_rise  = cs_b_s & ~st_reg.cs_q;
   assign hwp      = st_reg.guard_pin_enable & ~wp_b_s;                // R1 R2

   function automatic logic guarded(input logic [1:0] bp, input logic [13:0] a);
      logic g;
      g = 1'b0;
      unique case (bp)                                                 // R20
         2'b00: g = 1'b0;
         2'b01: g = (a >= `SEA_QUARTER_BASE);
         2'b10: g = (a >= `SEA_HALF_BASE);
         2'b11: g = 1'b1;
      endcase
      return g;
   endfunction

   function automatic logic [7:0] sr_view(input sea_state_t s);
      logic [7:0] v;
      v = 8'h00;
      v[`SEA_SR_GUARD_EN] = s.guard_pin_enable;                       // R19
      v[`SEA_SR_BG_HI]    = s.bp[1];
      v[`SEA_SR_BG_LO]    = s.bp[0];
      v[`SEA_SR_LATCH]    = s.write_latch_flag;
      v[`SEA_SR_BUSY]     = s.busy;
      // during a write every bit reads 1, busy among them
      return s.busy ? `SEA_SR_BUSY_VIEW : v;                          // R17
   endfunction

   always_comb begin
      logic [7:0]  ob;
      logic [4:0]  idx;
      logic [15:0] wt;
      ob      = 8'h00;
      idx     = 5'(st_reg.busy_cnt - 16'h0001);
      wt      = st_reg.wtime;
      st_next = st_reg;
      mem_we  = 1'b0;
      mem_wa  = {st_reg.addr[13:5], idx};
      mem_wd  = st_reg.pbuf[idx];
      st_next.sck_q = sck_s;
      st_next.cs_q  = cs_b_s;

      // internal write: one buffered byte per cycle in the last 32 counts
      if (st_reg.busy) begin
         mem_we = st_reg.wr_array && (st_reg.busy_cnt <= `SEA_PAGE_BYTES)
                  && st_reg.valid[idx];
         st_next.busy_cnt = st_reg.busy_cnt - 16'h0001;
         if (st_reg.busy_cnt == 16'h0001) begin
            st_next.busy = 1'b0;
            st_next.write_latch_flag = 1'b0;                           // R21
            if (!st_reg.wr_array) begin
               st_next.guard_pin_enable = st_reg.sw_byte[`SEA_SR_GUARD_EN];
               st_next.bp   = {st_reg.sw_byte[`SEA_SR_BG_HI], st_reg.sw_byte[`SEA_SR_BG_LO]};
            end
         end
      end

      if (cs_rise) begin
         st_next.phase     = P_OPC;                                    // R9
         st_next.bits      = 4'h0;
         st_next.so_oe_b   = 1'b1;                                     // R22
         st_next.lset_pend = 1'b0;
         st_next.byte_done = 1'b0;
         if (st_reg.lset_pend) begin
            st_next.write_latch_flag = 1'b1;                           // R11
         end
         // start only on a byte boundary with the latch set
         if (!st_reg.busy && st_reg.byte_done && st_reg.write_latch_flag) begin // R4 R15
            if (st_reg.op == `SEA_OP_ARRAY_WRITE && st_reg.phase == P_WR
                && !guarded(st_reg.bp, st_reg.addr)) begin             // R3
               st_next.busy     = 1'b1;
               st_next.wr_array = 1'b1;
               st_next.busy_cnt = st_reg.wtime;
            end else if (st_reg.op == `SEA_OP_STAT_WRITE && !hwp) begin // R3
               st_next.busy     = 1'b1;
               st_next.wr_array = 1'b0;
               st_next.busy_cnt = st_reg.wtime;
            end
         end
      end else if (!cs_b_s && sck_rise) begin
         st_next.shift     = {st_reg.shift[6:0], si_s};                // R5
         st_next.bits      = st_reg.bits + 4'h1;
         st_next.byte_done = 1'b0;
         unique case (st_reg.phase)
            P_OPC: begin
               if (st_reg.bits == `SEA_OPC_LAST) begin
                  st_next.op    = st_next.shift;
                  st_next.bits  = 4'h0;
                  st_next.phase = P_IGN;
                  // only a status read is served while writing
                  if (!st_reg.busy || st_next.shift == `SEA_OP_STAT_READ) begin // R10
                     if (st_next.shift == `SEA_OP_LATCH_SET) begin     // R18
                        st_next.lset_pend = 1'b1;
                     end else if (st_next.shift == `SEA_OP_LATCH_CLR) begin
                        st_next.write_latch_flag = 1'b0;
                     end else if (st_next.shift == `SEA_OP_STAT_READ) begin
                        st_next.phase   = P_SRD;
                        st_next.out_cnt = 3'h0;
                     end else if (st_next.shift == `SEA_OP_STAT_WRITE) begin
                        st_next.phase = P_SWR;
                     end else if (st_next.shift == `SEA_OP_ARRAY_READ
                                  || st_next.shift == `SEA_OP_ARRAY_WRITE) begin
                        st_next.phase = P_ADDR;
                     end
                  end
               end
            end
            P_ADDR: begin
               st_next.addr = {st_reg.addr[12:0], si_s};               // R6
               if (st_reg.bits == `SEA_ADDR_LAST) begin
                  st_next.bits    = 4'h0;
                  st_next.out_cnt = 3'h0;
                  if (st_reg.op == `SEA_OP_ARRAY_READ) begin
                     st_next.phase = P_RD;
                  end else begin
                     st_next.phase = P_WR;
                     st_next.wptr  = st_next.addr[4:0];
                     st_next.valid = 32'h0000_0000;
                  end
               end
            end
            P_WR: begin
               if (st_reg.bits == `SEA_OPC_LAST) begin
                  st_next.pbuf[st_reg.wptr]  = st_next.shift;
                  st_next.valid[st_reg.wptr] = 1'b1;
                  st_next.wptr      = st_reg.wptr + 5'h01;             // R13 R14
                  st_next.byte_done = 1'b1;
                  st_next.bits      = 4'h0;
               end
            end
            P_SWR: begin
               if (st_reg.bits == `SEA_OPC_LAST) begin
                  st_next.sw_byte   = st_next.shift;
                  st_next.byte_done = 1'b1;
                  st_next.phase     = P_IGN;
               end
            end
            P_IGN: begin
               // extra clocks after a latch set void it
               st_next.lset_pend = 1'b0;                               // R11
            end
            P_RD, P_SRD: begin
               st_next.bits = st_reg.bits;
            end
            default: begin
               st_next.phase = P_IGN;
            end
         endcase
      end else if (!cs_b_s && sck_fall
                   && (st_reg.phase == P_RD || st_reg.phase == P_SRD)) begin
         if (st_reg.out_cnt == 3'h0) begin
            ob = (st_reg.phase == P_RD) ? mem[st_reg.addr] : sr_view(st_reg); // R10
            st_next.so = ob[7];                                        // R5
            st_next.tx = {ob[6:0], 1'b0};
            if (st_reg.phase == P_RD) begin
               st_next.addr = st_reg.addr + 14'h0001;                  // R7 R8
            end
         end else begin
            st_next.so = st_reg.tx[7];
            st_next.tx = {st_reg.tx[6:0], 1'b0};
         end
         st_next.out_cnt = st_reg.out_cnt + 3'h1;
         st_next.so_oe_b = 1'b0;                                       // R22
      end

      // register bus: one wait cycle, then a single-cycle answer
      st_next.waitreq = 1'b1;
      if ((avs_read_in || avs_write_in) && st_reg.waitreq) begin
         st_next.waitreq = 1'b0;
         st_next.rdata   = 32'h0000_0000;
         if (avs_read_in && avs_address_in == `SEA_REG_STATUS) begin
            st_next.rdata = {22'h00_0000, ~cs_b_s, hwp, sr_view(st_reg)};
         end else if (avs_read_in && avs_address_in == `SEA_REG_WTIME) begin
            st_next.rdata = {16'h0000, st_reg.wtime};
         end
      end
      if (avs_write_in && !st_reg.waitreq && avs_address_in == `SEA_REG_WTIME) begin
         if (avs_byteenable_in[0]) begin
            wt[7:0] = avs_writedata_in[7:0];
         end
         if (avs_byteenable_in[1]) begin
            wt[15:8] = avs_writedata_in[15:8];
         end
         // too short a cycle could not reach every page byte
         st_next.wtime = (wt < `SEA_WTIME_MIN) ? `SEA_WTIME_MIN : wt;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (!rst_b_in) begin
         st_reg         <= '0;
         st_reg.cs_q    <= 1'b1;
         st_reg.phase   <= P_OPC;
         st_reg.so_oe_b <= 1'b1;
         st_reg.waitreq <= 1'b1;
         st_reg.wtime   <= WRITE_CYCLES;
      end else begin
         st_reg <= st_next;
      end
   end

   // array contents are not reset: nonvolatile in the real part
   always_ff @(posedge core_clk_in) begin
      if (mem_we) begin
         mem[mem_wa] <= mem_wd;
      end
   end

   assign avs_readdata_out    = st_reg.rdata;
   assign avs_waitrequest_out = st_reg.waitreq;
   assign spi_so_out          = st_reg.so;
   assign spi_so_oe_b_out     = st_reg.so_oe_b;

   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!rst_b_in);

   chk_hwp_status_block: assert property ( // R3
      cs_rise && !st_reg.busy && st_reg.op == `SEA_OP_STAT_WRITE && hwp |=> !st_reg.busy)
      else $error("status write started under hardware protection");
   chk_latch_needed: assert property ( // R4
      cs_rise && !st_reg.write_latch_flag && !st_reg.busy |=> !st_reg.busy)
      else $error("write started with latch clear");
   chk_read_increment: assert property ( // R7
      sck_fall && !cs_b_s && st_reg.phase == P_RD && st_reg.out_cnt == 3'h0
      |=> st_reg.addr == 14'($past(st_reg.addr) + 14'h0001))
      else $error("read address did not advance");
   chk_read_wrap: assert property ( // R8
      sck_fall && !cs_b_s && st_reg.phase == P_RD && st_reg.out_cnt == 3'h0
      && st_reg.addr == `SEA_ADDR_TOP |=> st_reg.addr == 14'h0000)
      else $error("read address did not wrap");
   chk_so_float_deselect: assert property ( // R22
      cs_b_s && st_reg.cs_q |=> spi_so_oe_b_out)
      else $error("serial output driven while deselected");
   chk_busy_reads_one: assert property ( // R17
      st_reg.busy && !cs_b_s && sck_fall && st_reg.phase == P_SRD && st_reg.out_cnt == 3'h0
      |=> spi_so_out && !spi_so_oe_b_out)
      else $error("status read during write missed busy");
   chk_latch_end_clear: assert property ( // R21
      st_reg.busy && st_reg.busy_cnt == 16'h0001 |=> !st_reg.write_latch_flag && !st_reg.busy)
      else $error("latch not cleared after write cycle");
   chk_latch_extra_clock: assert property ( // R11
      st_reg.lset_pend && sck_rise && !cs_b_s |=> !st_reg.lset_pend ##1 !st_reg.lset_pend)
      else $error("latch set survived extra clocks");
   chk_write_abort: assert property ( // R15
      cs_rise && !st_reg.busy && !st_reg.byte_done |=> !st_reg.busy)
      else $error("write started off a byte boundary");
   chk_page_wrap: assert property ( // R14
      sck_rise && !cs_b_s && st_reg.phase == P_WR && st_reg.bits == `SEA_OPC_LAST
      && st_reg.wptr == 5'h1F |=> st_reg.wptr == 5'h00)
      else $error("page pointer did not wrap");
endmodule // sea_engine

// *** logic/sea_pkg.sv ***
// Purpose: types of the serial eeprom access and guard block
// Assumes: nothing
// Notes: all state of the engine except the memory array and the pin synchroniser lives in one packed struct
package sea_pkg;
   typedef enum logic [2:0] {
      P_OPC  = 3'b000,
      P_ADDR = 3'b001,
      P_RD   = 3'b010,
      P_SRD  = 3'b011,
      P_WR   = 3'b100,
      P_SWR  = 3'b101,
      P_IGN  = 3'b110
   } sea_phase_t;

   typedef struct packed {
      logic             sck_q;
      logic             cs_q;
      sea_phase_t       phase;
      logic [3:0]       bits;
      logic [7:0]       shift;
      logic [7:0]       op;
      logic [13:0]      addr;
      logic [2:0]       out_cnt;
      logic [7:0]       tx;
      logic             so;
      logic             so_oe_b;
      logic             lset_pend;
      logic             byte_done;
      logic [4:0]       wptr;
      logic [31:0]      valid;
      logic [31:0][7:0] pbuf;
      logic [7:0]       sw_byte;
      logic             write_latch_flag;
      logic             busy;
      logic             wr_array;
      logic [15:0]      busy_cnt;
      logic             guard_pin_enable;
      logic [1:0]       bp;
      logic [15:0]      wtime;
      logic             waitreq;
      logic [31:0]      rdata;
   } sea_state_t;
endpackage

// *** logic/sea_sync.sv ***
// Purpose: two-flop synchroniser for pin inputs
// Assumes: pins are asynchronous to core_clk_in
// Notes: only the second stage may be read by logic
`timescale 1ns/1ns
module sea_sync #(
   parameter int         W       = 4,
   parameter logic [W-1:0] RST_VAL = '0
) (
   // clock and reset
   input  wire logic         core_clk_in,
   input  wire logic         rst_b_in,
   // data
   input  wire logic [W-1:0] d_in,
   output logic      [W-1:0] q_out
);
   if (W < 1) begin : g_bad_w
      $error("synchroniser needs at least one bit");
   end

   logic [W-1:0] meta_reg;
   logic [W-1:0] q_reg;

   always_ff @(posedge core_clk_in) begin
      if (!rst_b_in) begin
         meta_reg <= RST_VAL;
         q_reg    <= RST_VAL;
      end else begin
         meta_reg <= d_in;
         q_reg    <= meta_reg;
      end
   end

   assign q_out = q_reg;
endmodule // sea_sync

// *** verif/sea_engine_tb.sv ***
// Purpose: self-checking bench of the serial eeprom engine
// Assumes: write cycle length raised above its reset value through the WTIME register
// Notes: expectations queued by drivers, compared by a watching process
`timescale 1ns/1ns
module sea_engine_tb;
   logic        core_clk_in, rst_b_in, avs_read_in, avs_write_in;
   logic [3:0]  avs_address_in, be;
   logic [31:0] avs_writedata_in, avs_readdata_out, q;
   logic        avs_waitrequest_out, sck, cs_b, si, so, so_oe_b, so_last, so_w, guard_b;
   logic        rx_stb;
   logic [7:0]  rx_byte, v;
   logic [13:0] base;
   logic [8:0]  pg;
   logic [7:0]  mem [logic [13:0]];
   logic [63:0] qb[$];
   logic [7:0]  qs[$];
   int          n_errors, checked, k;

   always #2 core_clk_in = ~core_clk_in;
   // released output shows the inverse of its last driven level
   assign so_w = so_oe_b ? ~so_last : so;
   always @(posedge core_clk_in) if (so_oe_b === 1'b0) so_last <= so;

   sea_engine uut (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in),
      .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
      .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
      .avs_byteenable_in(be), .avs_readdata_out(avs_readdata_out),
      .avs_waitrequest_out(avs_waitrequest_out), .spi_sck_in(sck), .spi_cs_b_in(cs_b),
      .spi_si_in(si), .guard_pin_b_in(guard_b), .spi_so_out(so), .spi_so_oe_b_out(so_oe_b));
   sea_host_model h (.core_clk_in(core_clk_in), .so_in(so_w), .sck_out(sck), .cs_b_out(cs_b),
      .si_out(si), .rx_stb_out(rx_stb), .rx_byte_out(rx_byte));

   task automatic cmp(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e) begin
         n_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   always @(posedge core_clk_in) begin
      logic [63:0] x;
      if (avs_read_in && avs_waitrequest_out === 1'b0 && qb.size() > 0) begin
         x = qb.pop_front();
         if (x[63:32] != 32'h0) cmp(avs_readdata_out & x[63:32], x[31:0]);
      end
      if (rx_stb === 1'b1 && qs.size() > 0) cmp({24'h0, rx_byte}, {24'h0, qs.pop_front()});
   end
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // on a read, d is the expected value under mask m
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                      input logic [31:0] m, output logic [31:0] r);
      int n;
      if (!w) qb.push_back({m, d});
      avs_address_in <= a;
      avs_write_in <= w;
      avs_read_in <= !w;
      avs_writedata_in <= w ? d : $urandom;
      n = 0;
      do begin
         @(posedge core_clk_in);
         n++;
      end while (avs_waitrequest_out !== 1'b0 && n < 50);
      r = avs_readdata_out;
      if (n >= 50) begin
         n_errors++;
         stop_test();
      end
      avs_read_in <= 1'b0;
      avs_write_in <= 1'b0;
      @(posedge core_clk_in);
   endtask
   task automatic stat(input logic [31:0] e);
      bus(1'b0, 4'h0, e, 32'hFFFFFFFF, q);
   endtask
   task automatic wait_idle();
      int n;
      n = 0;
      do begin
         bus(1'b0, 4'h0, 32'h0, 32'h0, q);
         n++;
      end while (q[0] !== 1'b0 && n < 2000);
      if (n >= 2000) begin
         n_errors++;
         stop_test();
      end
   endtask
   task automatic cmd(input logic [7:0] op);
      h.sel();
      h.xb(op, 8, 1'b0);
      h.desel();
   endtask
   task automatic srd(input logic [7:0] e);
      qs.push_back(e);
      h.sel();
      h.xb(8'h05, 8, 1'b0);
      h.xb(8'h00, 8, 1'b1);
      h.desel();
   endtask
   task automatic swr(input logic [7:0] d, input logic ok);
      cmd(8'h06);
      h.sel();
      h.xb(8'h01, 8, 1'b0);
      h.xb(d, 8, 1'b0);
      h.desel();
      if (ok) wait_idle();
   endtask
   // tail adds loose bits after the data so that select rises mid-byte
   task automatic wr_arr(input logic [13:0] a, input int n, input logic lat,
                         input logic ok, input int tail);
      logic [7:0] b;
      int i;
      if (lat) cmd(8'h06);
      h.sel();
      h.xb(8'h02, 8, 1'b0);
      h.xb({2'b00, a[13:8]}, 8, 1'b0);
      h.xb(a[7:0], 8, 1'b0);
      for (i = 0; i < n; i++) begin
         b = 8'($urandom);
         h.xb(b, 8, 1'b0);
         if (ok) mem[{a[13:5], 5'(a[4:0] + i)}] = b;
      end
      if (tail > 0) h.xb(8'h00, tail, 1'b0);
      h.desel();
   endtask
   task automatic rd_arr(input logic [15:0] a, input int n);
      int i;
      h.sel();
      h.xb(8'h03, 8, 1'b0);
      h.xb(a[15:8], 8, 1'b0);
      h.xb(a[7:0], 8, 1'b0);
      for (i = 0; i < n; i++) begin
         qs.push_back(mem[14'(a + i)]);
         h.xb(8'h00, 8, 1'b1);
      end
      h.desel();
   endtask

   initial begin
      repeat (90000) @(posedge core_clk_in);
      n_errors++;
      stop_test();
   end
   initial begin
      core_clk_in = 1'b0;
      rst_b_in = 1'b0;
      avs_read_in = 1'b0;
      avs_write_in = 1'b0;
      avs_address_in = 4'h0;
      avs_writedata_in = 32'h0;
      guard_b = 1'b1;
      be = 4'hF;
      so_last = 1'b0;
      n_errors = 0;
      checked = 0;
      void'($urandom(35006));
      repeat (8) @(posedge core_clk_in);
      rst_b_in <= 1'b1;
      repeat (4) @(posedge core_clk_in);
      bus(1'b1, 4'h4, 32'h10, 32'h0, q);
      bus(1'b0, 4'h4, 32'h40, 32'hFFFFFFFF, q);
      bus(1'b1, 4'h4, 32'h800, 32'h0, q);
      bus(1'b0, 4'h8, 32'h0, 32'hFFFFFFFF, q);
      // only lane 1 enabled: low byte of the cycle count must survive
      be <= 4'h2;
      bus(1'b1, 4'h4, 32'h1234_0400, 32'h0, q);
      be <= 4'hF;
      bus(1'b0, 4'h4, 32'h400, 32'hFFFFFFFF, q);
      stat(32'h0);
      $display("test 1 done");
      wr_arr(14'h0100, 1, 1'b0, 1'b0, 0);
      stat(32'h0);
      h.sel();
      h.xb(8'h06, 8, 1'b0);
      h.xb(8'h00, 1, 1'b0);
      h.desel();
      stat(32'h0);
      cmd(8'h06);
      stat(32'h2);
      srd(8'h02);
      cmd(8'h04);
      stat(32'h0);
      $display("test 2 done");
      pg = 9'($urandom);
      wr_arr({pg, 5'h1F}, 33, 1'b1, 1'b1, 0);
      srd(8'hFF);
      wait_idle();
      stat(32'h0);
      rd_arr({2'b00, pg, 5'h00}, 32);
      $display("test 3 done");
      wr_arr(14'h3FFF, 1, 1'b1, 1'b1, 0);
      wait_idle();
      wr_arr(14'h0000, 1, 1'b1, 1'b1, 0);
      wait_idle();
      rd_arr(16'hFFFF, 2);
      srd(8'h00);
      cmp({31'h0, so_oe_b}, 32'h1);
      wr_arr(14'h0200, 1, 1'b1, 1'b0, 3);
      stat(32'h2);
      $display("test 4 done");
      for (k = 1; k <= 3; k++) begin
         v = {4'h0, 2'(k), 2'b00};
         base = (k == 1) ? 14'h3000 : (k == 2) ? 14'h2000 : 14'h0000;
         swr(v, 1'b1);
         stat({24'h0, v});
         wr_arr(base, 1, 1'b1, 1'b0, 0);
         stat({24'h0, v | 8'h02});
         if (k < 3) begin
            wr_arr(base - 14'h1, 1, 1'b0, 1'b1, 0);
            wait_idle();
            rd_arr({2'b00, base - 14'h1}, 1);
         end
      end
      $display("test 5 done");
      swr(8'h84, 1'b1);
      guard_b <= 1'b0;
      repeat (4) @(posedge core_clk_in);
      stat(32'h184);
      swr(8'h00, 1'b0);
      stat(32'h186);
      wr_arr(14'h3000, 1, 1'b1, 1'b0, 0);
      stat(32'h186);
      wr_arr(14'h0040, 1, 1'b0, 1'b1, 0);
      wait_idle();
      stat(32'h184);
      rd_arr(16'h0040, 1);
      guard_b <= 1'b1;
      repeat (4) @(posedge core_clk_in);
      stat(32'h84);
      swr(8'h00, 1'b1);
      stat(32'h0);
      $display("test 6 done");
      stop_test();
   end
endmodule // sea_engine_tb

// *** verif/sea_host_model.sv ***
// Purpose: host controller on the far side of the serial link
// Assumes: bench calls one task at a time, right after a core clock edge
// Notes: link clock stands low outside frames; every fourth low half is one
// core clock longer so the mean period is 125 ns
`timescale 1ns/1ns
module sea_host_model (
   // clock
   input  wire logic       core_clk_in,
   // serial link
   input  wire logic       so_in,
   output logic            sck_out,
   output logic            cs_b_out,
   output logic            si_out,
   // received byte
   output logic            rx_stb_out,
   output logic [7:0]      rx_byte_out
);
   int nbit;
   initial begin
      nbit = 0;
      sck_out = 1'b0;
      cs_b_out = 1'b1;
      si_out = 1'b0;
      rx_stb_out = 1'b0;
      rx_byte_out = 8'h00;
   end
   task automatic sel();
      cs_b_out <= 1'b0;
      repeat (16) @(posedge core_clk_in);
   endtask
   // select rises well after the last fall, so a frame ends on a whole count
   task automatic desel();
      repeat (8) @(posedge core_clk_in);
      cs_b_out <= 1'b1;
      si_out <= ~si_out;
      repeat (16) @(posedge core_clk_in);
   endtask
   // msb first; data set while clock low, output taken at the rise
   task automatic xb(input logic [7:0] tx, input int nb, input logic chk);
      logic [7:0] rx;
      int i;
      rx = 8'h00;
      for (i = 7; i >= 8 - nb; i--) begin
         si_out <= tx[i];
         repeat (15 + (nbit % 4 == 0)) @(posedge core_clk_in);
         nbit++;
         sck_out <= 1'b1;
         rx[i] = so_in;
         repeat (16) @(posedge core_clk_in);
         sck_out <= 1'b0;
      end
      if (chk) begin
         rx_byte_out <= rx;
         rx_stb_out <= 1'b1;
         @(posedge core_clk_in);
         rx_stb_out <= 1'b0;
      end
   endtask
endmodule // sea_host_model
